/* design/iepc_consts.svh */
// Purpose: Offsets, field positions, reset values and encodings of the
//          control-two and link-capability register bank.
// Assumes: Included by its bare name from design files.
// Notes:   Definitions only.
`ifndef IEPC_CONSTS_SVH
`define IEPC_CONSTS_SVH

// Register byte offsets on the plain register port
`define IEPC_AW 8
`define IEPC_OFF_DEVCTL2 8'h00
`define IEPC_OFF_LINKCAP 8'h04
`define IEPC_OFF_IRQ_STS 8'h08
`define IEPC_OFF_IRQ_MSK 8'h0C

// Device control two fields
`define IEPC_DC2_CTO_LSB 0
`define IEPC_DC2_CTO_MSB 3
`define IEPC_DC2_CTO_DIS 4
`define IEPC_DC2_ARI 5
`define IEPC_DC2_AT_REQ 6
`define IEPC_DC2_AT_BLK 7
`define IEPC_DC2_IDO_REQ 8
`define IEPC_DC2_IDO_CPL 9
`define IEPC_DC2_LTR 10
`define IEPC_DC2_EPR 11
`define IEPC_DC2_TAG10 12
`define IEPC_DC2_OBFF_LSB 13
`define IEPC_DC2_OBFF_MSB 14
`define IEPC_DC2_E2E_BLK 15
`define IEPC_DC2_RST 16'h0000

// Link capability fields
`define IEPC_LC_SPD_LSB 0
`define IEPC_LC_SPD_MSB 3
`define IEPC_LC_WID_LSB 4
`define IEPC_LC_WID_MSB 9
`define IEPC_LC_ASPM_LSB 10
`define IEPC_LC_ASPM_MSB 11
`define IEPC_LC_L1_LSB 15
`define IEPC_LC_L1_MSB 17
`define IEPC_LC_CLKPM 18
`define IEPC_LC_SDER 19
`define IEPC_LC_PORT_LSB 24
`define IEPC_LC_PORT_MSB 31

// Legal speed codes run from the lowest to the highest defined rate
`define IEPC_SPD_MIN 4'h1
`define IEPC_SPD_MAX 4'h6
`define IEPC_WID_X1 6'h01

// Interrupt event bits
`define IEPC_IRQ_W 4
`define IEPC_EV_DISCARD 0
`define IEPC_EV_AT_ERR 1
`define IEPC_EV_PFX 2
`define IEPC_EV_CAP_MISMATCH 3
`define IEPC_IRQ_RST 4'h0

`endif

/* design/iepc_pkg.sv */
// Purpose: Types shared by the register bank and its request gate.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only.
package iepc_pkg;

	// Which end of the integrated pair this instance sits in
	typedef enum logic {IEPC_ROLE_RP, IEPC_ROLE_EP} iepc_role_t;

	// Outcome for an incoming request
	typedef enum logic [1:0] {
		IEPC_V_NONE,
		IEPC_V_ACCEPT,
		IEPC_V_ERROR,
		IEPC_V_DISCARD
	} iepc_verdict_t;

endpackage

/* design/iepc_regs.sv */
// Purpose: Control-two and link-capability registers of one end of an
//          integrated root port and endpoint pair, with their effects.
// Assumes: All request inputs come from logic on clk_i.
// Notes:   Reads answer one cycle after the read strobe.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "iepc_consts.svh"
`default_nettype none
module iepc_regs
	import iepc_pkg::*;
#(
	parameter iepc_role_t ROLE = IEPC_ROLE_EP,
	parameter bit FWD_INVOLVED = 1'b0,
	parameter bit ATOMIC_CPL = 1'b1,
	parameter bit IDO_REQ_CAP = 1'b0,
	parameter bit IDO_CPL_CAP = 1'b0,
	parameter bit LTR_SUP = 1'b1,
	parameter bit OBFF_SUP = 1'b1,
	parameter logic [3:0] MAX_SPEED = 4'h1,
	parameter logic [5:0] MAX_WIDTH = 6'h01,
	parameter logic [2:0] L1_EXIT = 3'h0,
	parameter logic [7:0] PORT_NUM = 8'h00
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [`IEPC_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Incoming request classification
	input wire logic tlp_valid_i,
	input wire logic tlp_atomic_i,
	input wire logic tlp_prefix_i,
	output logic tlp_resp_valid_o,
	output logic tlp_accept_o,
	output logic tlp_error_o,
	output logic tlp_discard_o,
	// Latency tolerance messages from the endpoint toward the system
	input wire logic ltr_in_valid_i,
	input wire logic [31:0] ltr_in_data_i,
	output logic ltr_in_ready_o,
	output logic ltr_out_valid_o,
	output logic [31:0] ltr_out_data_o,
	input wire logic ltr_out_ready_i,
	// Buffer flush/fill state toward the endpoint
	input wire logic [1:0] obff_sys_i,
	output logic [1:0] obff_ep_o,
	// Ordering attribute controls toward the request engine
	output logic ido_req_attr_o,
	output logic ido_cpl_attr_o,
	// Capability agreement with the other end of the pair
	input wire logic [3:0] peer_max_speed_i,
	input wire logic [5:0] peer_max_width_i,
	output logic link_cap_match_o,
	// Interrupt
	output logic irq_o
);

	// Legal speed code, falling back to the lowest rate
	function automatic logic [3:0] iepc_legal_speed(input logic [3:0] s);
		if (s >= `IEPC_SPD_MIN && s <= `IEPC_SPD_MAX)
		begin
			iepc_legal_speed = s;
		end
		else
		begin
			iepc_legal_speed = `IEPC_SPD_MIN;
		end
	endfunction

	// Legal width code, falling back to a single lane
	function automatic logic [5:0] iepc_legal_width(input logic [5:0] w);
		case (w)
			6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20:
				iepc_legal_width = w;
			default:
				iepc_legal_width = `IEPC_WID_X1;
		endcase
	endfunction

	// Address match, used for every register decode
	function automatic logic iepc_hit(input logic [`IEPC_AW-1:0] a,
		input logic [`IEPC_AW-1:0] off);
		iepc_hit = (a == off);
	endfunction

	// Is this instance the root port end
	localparam bit IS_RP = (ROLE == IEPC_ROLE_RP);
	// Timeout fields live in an endpoint, and in a root port only where forwarding happens
	localparam bit CTO_LIVE = !IS_RP || FWD_INVOLVED;

	// Stored registers
	logic [15:0] dc2_reg; // Device control two storage
	logic [15:0] dc2_next; // Its next value
	logic [`IEPC_IRQ_W-1:0] sts_reg; // Sticky event status
	logic [`IEPC_IRQ_W-1:0] sts_next;
	logic [`IEPC_IRQ_W-1:0] msk_reg; // Interrupt mask
	logic [`IEPC_IRQ_W-1:0] msk_next;
	logic [31:0] rdata_reg; // Read answer
	logic [31:0] rdata_next;
	logic ltr_full_reg; // One held LTR message
	logic ltr_full_next;
	logic [31:0] ltr_data_reg;
	logic [31:0] ltr_data_next;
	logic [1:0] obff_reg; // State forwarded to the endpoint
	logic [1:0] obff_next;
	logic rv_reg; // Request verdict outputs
	logic acc_reg;
	logic err_reg;
	logic dis_reg;
	logic match_reg; // Capability agreement
	logic match_prev_reg; // Agreement one cycle back

	// Decoded strobes
	wire logic wr_dc2;
	wire logic wr_sts;
	wire logic wr_msk;
	wire logic rd_dc2;
	wire logic rd_lc;
	wire logic rd_sts;
	wire logic rd_msk;
	assign wr_dc2 = reg_wr_i & iepc_hit(reg_addr_i, `IEPC_OFF_DEVCTL2);
	assign wr_sts = reg_wr_i & iepc_hit(reg_addr_i, `IEPC_OFF_IRQ_STS);
	assign wr_msk = reg_wr_i & iepc_hit(reg_addr_i, `IEPC_OFF_IRQ_MSK);
	assign rd_dc2 = reg_rd_i & iepc_hit(reg_addr_i, `IEPC_OFF_DEVCTL2);
	assign rd_lc = reg_rd_i & iepc_hit(reg_addr_i, `IEPC_OFF_LINKCAP);
	assign rd_sts = reg_rd_i & iepc_hit(reg_addr_i, `IEPC_OFF_IRQ_STS);
	assign rd_msk = reg_rd_i & iepc_hit(reg_addr_i, `IEPC_OFF_IRQ_MSK);

	// Writable-bit mask: a zero here hardwires the field at zero
	logic [15:0] dc2_wmask;
	always_comb
	begin
		dc2_wmask = 16'h0000;
		// Timeout value and disable in an endpoint, and in a root port only where forwarding happens
		dc2_wmask[`IEPC_DC2_CTO_MSB:`IEPC_DC2_CTO_LSB] =
			{4{CTO_LIVE}};
		dc2_wmask[`IEPC_DC2_CTO_DIS] = CTO_LIVE;
		dc2_wmask[`IEPC_DC2_ARI] = 1'b1;
		// Requester enable exists only with an atomic completer
		dc2_wmask[`IEPC_DC2_AT_REQ] = ATOMIC_CPL;
		dc2_wmask[`IEPC_DC2_AT_BLK] = 1'b1;
		// Root port keeps these as inert storage
		dc2_wmask[`IEPC_DC2_IDO_REQ] = IS_RP || IDO_REQ_CAP;
		dc2_wmask[`IEPC_DC2_IDO_CPL] = IS_RP || IDO_CPL_CAP;
		dc2_wmask[`IEPC_DC2_LTR] = LTR_SUP;
		// Emergency power reduction request never stores
		dc2_wmask[`IEPC_DC2_EPR] = 1'b0;
		// Stored, but nothing below reads it
		dc2_wmask[`IEPC_DC2_TAG10] = 1'b1;
		dc2_wmask[`IEPC_DC2_OBFF_MSB:`IEPC_DC2_OBFF_LSB] = {2{OBFF_SUP}};
		dc2_wmask[`IEPC_DC2_E2E_BLK] = 1'b1;
	end

	// Named control fields
	wire logic at_req_en;
	wire logic at_blk;
	wire logic pfx_blk;
	wire logic ltr_en;
	wire logic obff_en;
	assign at_req_en = dc2_reg[`IEPC_DC2_AT_REQ];
	assign at_blk = dc2_reg[`IEPC_DC2_AT_BLK];
	assign pfx_blk = dc2_reg[`IEPC_DC2_E2E_BLK];
	assign ltr_en = LTR_SUP & dc2_reg[`IEPC_DC2_LTR];
	assign obff_en = OBFF_SUP &
		(|dc2_reg[`IEPC_DC2_OBFF_MSB:`IEPC_DC2_OBFF_LSB]);

	// Link capability word, built from constants only
	wire logic [3:0] lc_speed;
	wire logic [5:0] lc_width;
	logic [31:0] lc_word;
	assign lc_speed = iepc_legal_speed(MAX_SPEED);
	assign lc_width = iepc_legal_width(MAX_WIDTH);
	always_comb
	begin
		lc_word = 32'h0000_0000;
		lc_word[`IEPC_LC_SPD_MSB:`IEPC_LC_SPD_LSB] = lc_speed;
		lc_word[`IEPC_LC_WID_MSB:`IEPC_LC_WID_LSB] = lc_width;
		// Power management and surprise-down support read zero
		lc_word[`IEPC_LC_ASPM_MSB:`IEPC_LC_ASPM_LSB] = 2'h0;
		lc_word[`IEPC_LC_CLKPM] = 1'b0;
		lc_word[`IEPC_LC_SDER] = 1'b0;
		lc_word[`IEPC_LC_L1_MSB:`IEPC_LC_L1_LSB] = L1_EXIT;
		// Each root port instance is given its own number
		lc_word[`IEPC_LC_PORT_MSB:`IEPC_LC_PORT_LSB] = PORT_NUM;
	end

	// Request gate
	iepc_verdict_t verdict;
	iepc_req_gate u_gate (
		.req_valid_i(tlp_valid_i),
		.req_atomic_i(tlp_atomic_i),
		.req_prefix_i(tlp_prefix_i),
		.at_req_en_i(at_req_en),
		.at_blk_i(at_blk),
		.pfx_blk_i(pfx_blk),
		.verdict_o(verdict)
	);

	// Events from the gate and the capability check
	wire logic ev_discard;
	wire logic ev_at_err;
	wire logic ev_pfx;
	wire logic ev_mismatch;
	logic [`IEPC_IRQ_W-1:0] ev_vec;
	assign ev_discard = (verdict == IEPC_V_DISCARD);
	assign ev_at_err = (verdict == IEPC_V_ERROR) & tlp_atomic_i &
		~at_req_en;
	assign ev_pfx = (verdict == IEPC_V_ERROR) & tlp_prefix_i & pfx_blk;
	// Raised once when the pair stops agreeing
	assign ev_mismatch = match_prev_reg & ~match_reg;
	always_comb
	begin
		ev_vec = `IEPC_IRQ_RST;
		ev_vec[`IEPC_EV_DISCARD] = ev_discard;
		ev_vec[`IEPC_EV_AT_ERR] = ev_at_err;
		ev_vec[`IEPC_EV_PFX] = ev_pfx;
		ev_vec[`IEPC_EV_CAP_MISMATCH] = ev_mismatch;
	end

	// Fixed bits keep their value, writable ones take the write
	assign dc2_next = wr_dc2 ?
		(reg_wdata_i[15:0] & dc2_wmask) : dc2_reg;

	// Sticky status: a new event beats a same-cycle clear
	assign sts_next = (sts_reg &
		~(wr_sts ? reg_wdata_i[`IEPC_IRQ_W-1:0] : `IEPC_IRQ_RST)) | ev_vec;
	assign msk_next = wr_msk ? reg_wdata_i[`IEPC_IRQ_W-1:0] : msk_reg;

	// Read answer, zero for unmapped offsets
	assign rdata_next =
		rd_dc2 ? {16'h0000, dc2_reg} :
		rd_lc ? lc_word :
		rd_sts ? {{(32-`IEPC_IRQ_W){1'b0}}, sts_reg} :
		rd_msk ? {{(32-`IEPC_IRQ_W){1'b0}}, msk_reg} :
		32'h0000_0000;

	// LTR holding slot: disabled means taken and dropped
	wire logic ltr_take;
	wire logic ltr_give;
	assign ltr_give = ltr_full_reg & ltr_out_ready_i;
	assign ltr_in_ready_o = ~ltr_en | ~ltr_full_reg | ltr_out_ready_i;
	assign ltr_take = ltr_in_valid_i & ltr_in_ready_o & ltr_en;
	assign ltr_full_next = ltr_take | (ltr_full_reg & ~ltr_give);
	assign ltr_data_next = ltr_take ? ltr_in_data_i : ltr_data_reg;

	// Buffer state reaches the endpoint only when enabled
	assign obff_next = obff_en ? obff_sys_i : 2'h0;

	// Control and status registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dc2_reg <= `IEPC_DC2_RST;
			sts_reg <= `IEPC_IRQ_RST;
			msk_reg <= `IEPC_IRQ_RST;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			dc2_reg <= dc2_next;
			sts_reg <= sts_next;
			msk_reg <= msk_next;
			rdata_reg <= rdata_next;
		end
	end

	// LTR slot and OBFF state
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ltr_full_reg <= 1'b0;
			ltr_data_reg <= 32'h0000_0000;
			obff_reg <= 2'h0;
		end
		else
		begin
			ltr_full_reg <= ltr_full_next;
			ltr_data_reg <= ltr_data_next;
			obff_reg <= obff_next;
		end
	end

	// Registered verdict, one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rv_reg <= 1'b0;
			acc_reg <= 1'b0;
			err_reg <= 1'b0;
			dis_reg <= 1'b0;
		end
		else
		begin
			rv_reg <= (verdict != IEPC_V_NONE);
			acc_reg <= (verdict == IEPC_V_ACCEPT);
			err_reg <= (verdict == IEPC_V_ERROR);
			dis_reg <= (verdict == IEPC_V_DISCARD);
		end
	end

	// Both ends must report the same maximum speed and width
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			match_reg <= 1'b1;
			match_prev_reg <= 1'b1;
		end
		else
		begin
			match_reg <= (peer_max_speed_i == lc_speed) &&
				(peer_max_width_i == lc_width);
			match_prev_reg <= match_reg;
		end
	end

	// Outputs
	assign reg_rdata_o = rdata_reg;
	assign tlp_resp_valid_o = rv_reg;
	assign tlp_accept_o = acc_reg;
	assign tlp_error_o = err_reg;
	assign tlp_discard_o = dis_reg;
	assign ltr_out_valid_o = ltr_full_reg;
	assign ltr_out_data_o = ltr_data_reg;
	assign obff_ep_o = obff_reg;
	// Root port never marks from these bits
	assign ido_req_attr_o = !IS_RP & IDO_REQ_CAP &
		dc2_reg[`IEPC_DC2_IDO_REQ];
	assign ido_cpl_attr_o = !IS_RP & IDO_CPL_CAP &
		dc2_reg[`IEPC_DC2_IDO_CPL];
	assign link_cap_match_o = match_reg;
	// Level interrupt while any unmasked status bit is set
	assign irq_o = |(sts_reg & msk_reg);

endmodule
`default_nettype wire

/* design/iepc_req_gate.sv */
// Purpose: Decide accept, error answer or silent discard for a request.
// Assumes: Inputs come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`default_nettype none
module iepc_req_gate
	import iepc_pkg::*;
(
	input wire logic req_valid_i,
	input wire logic req_atomic_i,
	input wire logic req_prefix_i,
	input wire logic at_req_en_i,
	input wire logic at_blk_i,
	input wire logic pfx_blk_i,
	output iepc_verdict_t verdict_o
);

	// Named conditions, highest priority first
	wire logic blk_hit;
	wire logic pfx_hit;
	wire logic at_off_hit;

	// Egress blocking drops atomics outright
	assign blk_hit = req_valid_i & req_atomic_i & at_blk_i;
	// Prefixed traffic is blocked while prefix blocking is set
	assign pfx_hit = req_valid_i & req_prefix_i & pfx_blk_i;
	// Atomics with the requester enable clear earn an error answer
	assign at_off_hit = req_valid_i & req_atomic_i & ~at_req_en_i;

	// Priority selection of the verdict
	always_comb
	begin
		if (!req_valid_i)
		begin
			verdict_o = IEPC_V_NONE;
		end
		else if (blk_hit)
		begin
			verdict_o = IEPC_V_DISCARD;
		end
		else if (pfx_hit || at_off_hit)
		begin
			verdict_o = IEPC_V_ERROR;
		end
		else
		begin
			// Enabled atomics and ordinary traffic pass
			verdict_o = IEPC_V_ACCEPT;
		end
	end

endmodule
`default_nettype wire

/* sim/iepc_peer_model.sv */
// Purpose: Far end of the pair: peer capabilities and LTR traffic.
// Assumes: Bench calls its task and sets stall_reg on rising edges.
// Notes: The data line shows the inverse of the last word when idle.
`timescale 1ns/1ps
`default_nettype none
module iepc_peer_model (
	input wire logic clk_i,
	input wire logic ltr_ready_i,
	input wire logic ltr_valid_i,
	input wire logic [31:0] ltr_data_i,
	output logic ltr_valid_o,
	output logic [31:0] ltr_data_o,
	output logic ltr_ready_o,
	output logic [3:0] speed_o,
	output logic [5:0] width_o
);
	// System-side stall and the words taken from the slot
	logic stall_reg = 1'b0;
	logic [31:0] got_q [$];
	// Idle values; legal capability codes equal to the near end
	initial
	begin
		ltr_valid_o = 1'b0;
		ltr_data_o = 32'h0000_0000;
		speed_o = 4'h1;
		width_o = 6'h01;
	end
	assign ltr_ready_o = !stall_reg;
	// Collect what the system takes
	always @(posedge clk_i)
		if (ltr_valid_i && ltr_ready_o)
			got_q.push_back(ltr_data_i);
	// Offer one message and hold it until taken, giving up after 50 waiting cycles
	task send(input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		ltr_valid_o <= 1'b1;
		ltr_data_o <= d;
		@(posedge clk_i);
		while (!ltr_ready_i && n < 50)
		begin
			n++;
			@(posedge clk_i);
		end
		// A message never taken counts against the run
		if (n >= 50)
			tb.bad_count++;
		ltr_valid_o <= 1'b0;
		ltr_data_o <= ~d;
	endtask
endmodule
`default_nettype wire

/* sim/iepc_regs_asserts.sv */
// Purpose: Port-level checks of the control-two register bank.
// Assumes: Default parameters of iepc_regs (endpoint role).
// Notes: Mirrors the gating and mask bits from register writes.
`timescale 1ns/1ps
`include "iepc_consts.svh"
`default_nettype none
module iepc_regs_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [`IEPC_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic tlp_valid_i,
	input wire logic tlp_atomic_i,
	input wire logic tlp_prefix_i,
	input wire logic tlp_resp_valid_o,
	input wire logic tlp_accept_o,
	input wire logic tlp_error_o,
	input wire logic tlp_discard_o,
	input wire logic ltr_in_valid_i,
	input wire logic [31:0] ltr_in_data_i,
	input wire logic ltr_in_ready_o,
	input wire logic ltr_out_valid_o,
	input wire logic [31:0] ltr_out_data_o,
	input wire logic ltr_out_ready_i,
	input wire logic [3:0] peer_max_speed_i,
	input wire logic [5:0] peer_max_width_i,
	input wire logic link_cap_match_o,
	input wire logic irq_o
);
	// Copies of control two and the mask
	logic [15:0] dc2_reg;
	logic [3:0] msk_reg;
	wire logic wr_dc2 = reg_wr_i && reg_addr_i == `IEPC_OFF_DEVCTL2;
	wire logic wr_msk = reg_wr_i && reg_addr_i == `IEPC_OFF_IRQ_MSK;
	wire logic at_en = dc2_reg[`IEPC_DC2_AT_REQ];
	wire logic at_blk = dc2_reg[`IEPC_DC2_AT_BLK];
	wire logic pfx_blk = dc2_reg[`IEPC_DC2_E2E_BLK];
	wire logic atomic_req = tlp_valid_i && tlp_atomic_i;
	// Follow writes so the gating state is known
	always_ff @(posedge clk_i)
		if (!rst_n_i)
			dc2_reg <= 16'h0000;
		else if (wr_dc2)
			dc2_reg <= reg_wdata_i[15:0];
	// Follow mask writes
	always_ff @(posedge clk_i)
		if (!rst_n_i)
			msk_reg <= 4'h0;
		else if (wr_msk)
			msk_reg <= reg_wdata_i[3:0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// One answer with exactly one verdict bit
	sequence s_verdict(acc, err, dis);
		tlp_resp_valid_o && tlp_accept_o == acc && tlp_error_o == err && tlp_discard_o == dis;
	endsequence
	// Discarded atomic with its status bit unmasked
	sequence s_discard_seen;
		atomic_req && at_blk && msk_reg[`IEPC_EV_DISCARD];
	endsequence
	a_egress_discard: assert property (
		atomic_req && at_blk |=> s_verdict(1'b0, 1'b0, 1'b1)) else $error("atomic not dropped");
	a_atomic_error: assert property (
		atomic_req && !at_blk && !at_en |=> s_verdict(1'b0, 1'b1, 1'b0)) else $error("no error");
	a_atomic_accept: assert property (
		atomic_req && !at_blk && at_en && !(tlp_prefix_i && pfx_blk)
		|=> s_verdict(1'b1, 1'b0, 1'b0)) else $error("atomic not accepted");
	a_prefix_block: assert property (
		tlp_valid_i && tlp_prefix_i && pfx_blk && !(tlp_atomic_i && at_blk)
		|=> s_verdict(1'b0, 1'b1, 1'b0)) else $error("prefix not blocked");
	a_discard_logged: assert property (
		s_discard_seen |-> ##[1:3] irq_o) else $error("discard not logged");
	a_ltr_deliver: assert property (
		ltr_in_valid_i && ltr_in_ready_o && dc2_reg[`IEPC_DC2_LTR]
		|=> ltr_out_valid_o && ltr_out_data_o == $past(ltr_in_data_i)) else $error("ltr lost");
	a_ltr_hold: assert property (
		ltr_out_valid_o && !ltr_out_ready_i |=> ltr_out_valid_o && $stable(ltr_out_data_o))
		else $error("ltr not held");
	a_cap_match: assert property (
		1'b1 |=> link_cap_match_o == ($past(peer_max_speed_i) == `IEPC_SPD_MIN
		&& $past(peer_max_width_i) == `IEPC_WID_X1)) else $error("match wrong");
	a_linkcap_fixed: assert property (
		reg_rd_i && reg_addr_i == `IEPC_OFF_LINKCAP |=> reg_rdata_o == 32'h0000_0011)
		else $error("link capability wrong");
	a_devctl_fixed: assert property (
		reg_rd_i && reg_addr_i == `IEPC_OFF_DEVCTL2 |=> (reg_rdata_o & 32'hFFFF_0B00) == 32'h0)
		else $error("fixed bit set");
endmodule
bind iepc_regs iepc_regs_asserts iepc_regs_asserts_inst (.clk_i, .rst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tlp_valid_i, .tlp_atomic_i,
	.tlp_prefix_i, .tlp_resp_valid_o, .tlp_accept_o, .tlp_error_o, .tlp_discard_o,
	.ltr_in_valid_i, .ltr_in_data_i, .ltr_in_ready_o, .ltr_out_valid_o, .ltr_out_data_o,
	.ltr_out_ready_i, .peer_max_speed_i, .peer_max_width_i, .link_cap_match_o, .irq_o);
`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench of the control-two register bank.
// Assumes: Default parameters: endpoint, atomic completer, LTR, OBFF.
// Notes: One task per scenario; comparisons go through check.
`timescale 1ns/1ps
`include "iepc_consts.svh"
`default_nettype none
module tb;
	// Signals carry the design's port names
	logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic tlp_valid_i = 1'b0, tlp_atomic_i = 1'b0, tlp_prefix_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, ltr_in_data_i, ltr_out_data_o;
	logic [1:0] obff_sys_i = 2'h0, obff_ep_o;
	logic [3:0] peer_max_speed_i;
	logic [5:0] peer_max_width_i;
	logic tlp_resp_valid_o, tlp_accept_o, tlp_error_o, tlp_discard_o, ltr_in_valid_i;
	logic ltr_in_ready_o, ltr_out_valid_o, ltr_out_ready_i, ido_req_attr_o, ido_cpl_attr_o;
	logic link_cap_match_o, irq_o;
	int bad_count = 0, n_compared = 0;
	iepc_regs iepc_regs_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .tlp_valid_i, .tlp_atomic_i, .tlp_prefix_i,
		.tlp_resp_valid_o, .tlp_accept_o, .tlp_error_o, .tlp_discard_o, .ltr_in_valid_i,
		.ltr_in_data_i, .ltr_in_ready_o, .ltr_out_valid_o, .ltr_out_data_o,
		.ltr_out_ready_i, .obff_sys_i, .obff_ep_o, .ido_req_attr_o, .ido_cpl_attr_o,
		.peer_max_speed_i, .peer_max_width_i, .link_cap_match_o, .irq_o);
	iepc_peer_model iepc_peer_model_inst (.clk_i, .ltr_ready_i(ltr_in_ready_o),
		.ltr_valid_i(ltr_out_valid_o), .ltr_data_i(ltr_out_data_o),
		.ltr_valid_o(ltr_in_valid_i), .ltr_data_o(ltr_in_data_i),
		.ltr_ready_o(ltr_out_ready_i), .speed_o(peer_max_speed_i), .width_o(peer_max_width_i));
	// 100 MHz clock
	initial
		forever #5 clk_i = ~clk_i;
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle write, then one settling edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// One-cycle read; data stand in the next cycle only
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		check(reg_rdata_o, exp);
	endtask
	// Offer a request and judge the verdict one cycle later
	task req(input logic at, input logic pf, input logic [2:0] exp);
		@(posedge clk_i);
		tlp_valid_i <= 1'b1;
		tlp_atomic_i <= at;
		tlp_prefix_i <= pf;
		@(posedge clk_i);
		tlp_valid_i <= 1'b0;
		@(posedge clk_i);
		check({tlp_resp_valid_o, tlp_accept_o, tlp_error_o, tlp_discard_o}, {1'b1, exp});
	endtask
	task t_fixed;
		rdc(`IEPC_OFF_DEVCTL2, 32'h0000_0000);
		rdc(`IEPC_OFF_LINKCAP, 32'h0000_0011);
		rdc(8'h10, 32'h0000_0000);
		wr(`IEPC_OFF_DEVCTL2, 32'hFFFF_FFFF);
		rdc(`IEPC_OFF_DEVCTL2, 32'h0000_F4FF);
		check({ido_req_attr_o, ido_cpl_attr_o}, 32'h0);
		wr(`IEPC_OFF_LINKCAP, 32'hFFFF_FFFF);
		rdc(`IEPC_OFF_LINKCAP, 32'h0000_0011);
		$display("test fixed done");
	endtask
	// Each row: control two, atomic, prefix, accept/error/discard
	task t_requests;
		static logic [20:0] tbl [6] = '{{16'h0040, 5'b10100}, {16'h1000, 5'b10010},
			{16'h00C0, 5'b10001}, {16'h8040, 5'b01010}, {16'h0040, 5'b01100},
			{16'h80C0, 5'b11001}};
		wr(`IEPC_OFF_IRQ_MSK, 32'h0000_0001);
		for (int i = 0; i < 6; i++)
		begin
			wr(`IEPC_OFF_DEVCTL2, {16'h0000, tbl[i][20:5]});
			req(tbl[i][4], tbl[i][3], tbl[i][2:0]);
		end
		rdc(`IEPC_OFF_IRQ_STS, 32'h0000_0007);
		check(irq_o, 32'h1);
		wr(`IEPC_OFF_IRQ_MSK, 32'h0000_0000);
		check(irq_o, 32'h0);
		wr(`IEPC_OFF_IRQ_STS, 32'h0000_0005);
		rdc(`IEPC_OFF_IRQ_STS, 32'h0000_0002);
		wr(`IEPC_OFF_IRQ_STS, 32'h0000_0002);
		$display("test requests done");
	endtask
	// Message held while the system stalls, then drained in order
	task t_ltr;
		wr(`IEPC_OFF_DEVCTL2, 32'h0000_0400);
		iepc_peer_model_inst.stall_reg <= 1'b1;
		iepc_peer_model_inst.send(32'hA5A5_0001);
		repeat (4) @(posedge clk_i);
		check(ltr_out_valid_o, 32'h1);
		check(ltr_out_data_o, 32'hA5A5_0001);
		check(ltr_in_ready_o, 32'h0);
		iepc_peer_model_inst.stall_reg <= 1'b0;
		iepc_peer_model_inst.send(32'h5A5A_0002);
		repeat (3) @(posedge clk_i);
		check(iepc_peer_model_inst.got_q.size(), 32'h2);
		check(iepc_peer_model_inst.got_q[1], 32'h5A5A_0002);
		wr(`IEPC_OFF_DEVCTL2, 32'h0000_0000);
		// Stall again so a wrongly taken message would stay visible
		iepc_peer_model_inst.stall_reg <= 1'b1;
		iepc_peer_model_inst.send(32'h0000_0003);
		repeat (2) @(posedge clk_i);
		check(ltr_out_valid_o, 32'h0);
		check(iepc_peer_model_inst.got_q.size(), 32'h2);
		$display("test ltr done");
	endtask
	task t_obff;
		wr(`IEPC_OFF_DEVCTL2, 32'h0000_2000);
		obff_sys_i <= 2'h2;
		repeat (2) @(posedge clk_i);
		check(obff_ep_o, 32'h2);
		wr(`IEPC_OFF_DEVCTL2, 32'h0000_0000);
		@(posedge clk_i);
		check(obff_ep_o, 32'h0);
		$display("test obff done");
	endtask
	task t_caps;
		check(link_cap_match_o, 32'h1);
		iepc_peer_model_inst.speed_o <= 4'h2;
		repeat (3) @(posedge clk_i);
		check(link_cap_match_o, 32'h0);
		rdc(`IEPC_OFF_IRQ_STS, 32'h0000_0008);
		iepc_peer_model_inst.speed_o <= 4'h1;
		iepc_peer_model_inst.width_o <= 6'h04;
		repeat (3) @(posedge clk_i);
		check(link_cap_match_o, 32'h0);
		iepc_peer_model_inst.width_o <= 6'h01;
		repeat (3) @(posedge clk_i);
		check(link_cap_match_o, 32'h1);
		$display("test caps done");
	endtask
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well beyond the roughly 120 cycles expected
	initial
	begin
		#100us;
		bad_count++;
		summarize;
	end
	// Reset for four cycles, then the scenarios
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_fixed;
		t_requests;
		t_ltr;
		t_obff;
		t_caps;
		summarize;
	end
endmodule
`default_nettype wire
